// ==== src/scc_consts.svh ====
// offsets, field positions, voltage tables and timing counts of the strap capture block
`ifndef SCC_CONSTS_SVH
`define SCC_CONSTS_SVH

`define SCC_OFS_CTRL          12'h000
`define SCC_OFS_STATUS        12'h004
`define SCC_OFS_PINS          12'h008
`define SCC_OFS_ADDR          12'h00C
`define SCC_OFS_VSET          12'h010
`define SCC_OFS_VCEIL         12'h014
`define SCC_OFS_NVM           12'h018

`define SCC_CTRL_RESTORE      0
`define SCC_CTRL_STORE        1

`define SCC_RESP_OKAY         2'h0
`define SCC_RESP_SLVERR       2'h2

`define SCC_NPINS             4
`define SCC_PIN_W             8
`define SCC_PIN_ADDR_LO       0
`define SCC_PIN_ADDR_HI       1
`define SCC_PIN_VOUT_FINE     2
`define SCC_PIN_VOUT_COARSE   3
`define SCC_SENSE_ABOVE_HIGH  0
`define SCC_SENSE_BELOW_LOW   1
`define SCC_SENSE_RES_DET     2
`define SCC_SENSE_IDX_LSB     3
`define SCC_RES_SELECTIONS    31

`define SCC_ADDR_BASE         7'h20
`define SCC_ADDR_RES_BASE     7'h40
`define SCC_STRAP_STATES      3

`define SCC_VOUT_MIN_MV       16'h0258
`define SCC_OUTPUT_VOLTAGE_CEILING_MV       16'h0E10
`define SCC_VSTEP_MV          16'h000A
`define SCC_STEPS_PER_COARSE  16'h0019
`define SCC_CEIL_NUM          20'h0000B
`define SCC_CEIL_DEN          20'h0000A
`define SCC_VSTRAP_MV_0       16'h0258
`define SCC_VSTRAP_MV_1       16'h0320
`define SCC_VSTRAP_MV_2       16'h03E8
`define SCC_VSTRAP_MV_3       16'h04B0
`define SCC_VSTRAP_MV_4       16'h05DC
`define SCC_VSTRAP_MV_5       16'h0708
`define SCC_VSTRAP_MV_6       16'h09C4
`define SCC_VSTRAP_MV_7       16'h0CE4
`define SCC_VSTRAP_MV_8       16'h0E10

`define SCC_CLK_PERIOD_NS     20
`define SCC_SETTLE_NS         10000
`define SCC_SETTLE_CYC        ((`SCC_SETTLE_NS + `SCC_CLK_PERIOD_NS - 1) / `SCC_CLK_PERIOD_NS)
`define SCC_NVM_WRITE_NS      40000
`define SCC_NVM_WRITE_CYC     ((`SCC_NVM_WRITE_NS + `SCC_CLK_PERIOD_NS - 1) / `SCC_CLK_PERIOD_NS)

`endif

// ==== src/scc_pkg.sv ====
// types shared by the strap capture block
package scc_pkg;
   typedef enum logic [1:0] {
      SCC_PIN_LOW  = 2'h0,
      SCC_PIN_OPEN = 2'h1,
      SCC_PIN_HIGH = 2'h2,
      SCC_PIN_RES  = 2'h3
   } scc_pin_class_t;

   // gray sequence idle -> sample -> decode -> ready
   typedef enum logic [1:0] {
      SCC_ST_IDLE   = 2'h0,
      SCC_ST_SAMPLE = 2'h1,
      SCC_ST_DECODE = 2'h3,
      SCC_ST_READY  = 2'h2
   } scc_fsm_t;
endpackage : scc_pkg

// ==== src/scc_pin_if.sv ====
// carrier between the capture controller and the pin sampler
`timescale 1ns/1ps
interface scc_pin_if;
   logic                      sample_req;
   logic                      sample_done;
   scc_pkg::scc_pin_class_t   cls [4];
   logic [3:0][4:0]           idx;
   modport ctrl (output sample_req, input sample_done, input cls, input idx);
   modport smp  (input sample_req, output sample_done, output cls, output idx);
endinterface : scc_pin_if

// ==== src/scc_pin_sampler.sv ====
// synchronises the multi-mode pin sense lines and classifies each pin on request
`timescale 1ns/1ps
`include "scc_consts.svh"
module scc_pin_sampler #(
   parameter int SETTLE_CYC = `SCC_SETTLE_CYC
) (
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   input  wire logic [31:0]           pin_sense,
   scc_pin_if.smp                     pif
);
   if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_bad_settle
      $error("scc_pin_sampler: SETTLE_CYC out of range");
   end

   typedef struct packed {
      logic [31:0]                         s1;
      logic [31:0]                         s2;
      logic [31:0]                         s3;
      logic [15:0]                         cnt;
      logic                                busy;
      logic                                done;
      logic [3:0][1:0]                     cls;
      logic [3:0][4:0]                     idx;
   } scc_smp_t;

   scc_smp_t            st_q;
   scc_smp_t            st_d;
   logic [3:0][1:0]     cls_now;
   logic [3:0][4:0]     idx_now;

   // tied low wins over a resistor, out-of-table resistance reads as open
   for (genvar p = 0; p < `SCC_NPINS; p++) begin : g_pin
      logic [7:0] sv;
      assign sv         = st_q.s3[p*`SCC_PIN_W +: `SCC_PIN_W];
      assign idx_now[p] = sv[`SCC_SENSE_IDX_LSB +: 5];
      always_comb begin
         if (sv[`SCC_SENSE_ABOVE_HIGH])
            cls_now[p] = scc_pkg::SCC_PIN_HIGH;
         else if (sv[`SCC_SENSE_BELOW_LOW])
            cls_now[p] = scc_pkg::SCC_PIN_LOW;
         else if (sv[`SCC_SENSE_RES_DET] && idx_now[p] < 5'(`SCC_RES_SELECTIONS))
            cls_now[p] = scc_pkg::SCC_PIN_RES;
         else
            cls_now[p] = scc_pkg::SCC_PIN_OPEN;
      end
      assign pif.cls[p] = scc_pkg::scc_pin_class_t'(st_q.cls[p]);
   end

   always_comb begin
      st_d      = st_q;
      st_d.s1   = pin_sense;
      st_d.s2   = st_q.s1;
      st_d.s3   = st_q.s2;
      st_d.done = 1'b0;
      if (!st_q.busy && pif.sample_req) begin
         st_d.busy = 1'b1;
         st_d.cnt  = 16'(SETTLE_CYC);
      end else if (st_q.busy) begin
         if (st_q.cnt != 16'h0000)
            st_d.cnt = st_q.cnt - 16'h0001;
         else if (st_q.s2 == st_q.s3) begin
            st_d.cls  = cls_now;
            st_d.idx  = idx_now;
            st_d.done = 1'b1;
            st_d.busy = 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) st_q <= '0;
      else        st_q <= st_d;
   end

   assign pif.sample_done = st_q.done;
   assign pif.idx         = st_q.idx;

   chk_done_ends_busy: assert property (@(posedge clock) disable iff (!rst_n)
      st_q.done |-> !st_q.busy && $past(st_q.busy))
      else $error("sample done without a running sample");
endmodule : scc_pin_sampler

// ==== src/scc_strap_capture.sv ====
// strap configuration capture with an AXI4-Lite register slave
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "scc_consts.svh"
// How it works
// - pins are sampled after reset release and on each restore command given while no sample is running.
// - each pin is classed low, open, high or resistor to signal ground.
// - one strap pin gives three settings, a pin pair gives nine.
// - a recognised resistor maps to one of 31 selections.
// - pin-derived settings stay readable over the register bus.
// - address and voltage ceiling come only from pins; set-point is also host-writable.
// - serial address follows from the two address-select pins.
// - voltage ceiling is the pin set-point plus ten percent.
// - software can store the current set-point into non-volatile storage.
// - every strapped address-select combination gives a different serial address; with a resistor on the low pin the high pin is ignored.
// - strapped voltage pins pick one of nine set-points, 0.6 V to 3.6 V.
module scc_strap_capture #(
   parameter int SETTLE_CYC = `SCC_SETTLE_CYC,
   parameter int NVM_CYC    = `SCC_NVM_WRITE_CYC
) (
   input  wire logic          clock,
   input  wire logic          rst_n,
   input  wire logic [31:0]   pin_sense,
   output logic               config_ready,
   output logic [6:0]         serial_addr,
   output logic [15:0]        vout_setpoint_mv,
   output logic [15:0]        output_voltage_ceiling,
   output logic               nvm_busy,
   input  wire logic [11:0]   s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [11:0]   s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready
);
   if (NVM_CYC < 1 || NVM_CYC > 65535) begin : g_bad_nvm
      $error("scc_strap_capture: NVM_CYC out of range");
   end

   typedef struct packed {
      scc_pkg::scc_fsm_t   fsm;
      logic                ready;
      logic [6:0]          addr;
      logic [15:0]         vset;
      logic [15:0]         vceil;
      logic [15:0]         nvm_vout;
      logic                nvm_busy;
      logic [15:0]         nvm_cnt;
      logic                req;
      logic                aw_got;
      logic [11:0]         awaddr;
      logic                w_got;
      logic [31:0]         wdata;
      logic [3:0]          wstrb;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                rvalid;
      logic [31:0]         rdata;
      logic [1:0]          rresp;
   } scc_top_t;

   localparam scc_top_t RESET_ST = '{fsm: scc_pkg::SCC_ST_SAMPLE, req: 1'b1, default: '0};

   scc_top_t            st_q;
   scc_top_t            st_d;
   scc_pin_if           pif ();
   logic [11:0]         wr_addr;
   logic [31:0]         wr_data;
   logic [3:0]          wr_strb;
   logic                wr_fire;
   logic                rd_fire;
   logic [15:0]         pin_mv;
   logic [6:0]          pin_addr;
   logic [19:0]         ceil_full;
   logic [15:0]         host_mv;
   logic [15:0]         host_hi;

   scc_pin_sampler #(.SETTLE_CYC(SETTLE_CYC)) u_sampler (
      .clock     (clock),
      .rst_n     (rst_n),
      .pin_sense (pin_sense),
      .pif       (pif)
   );

   function automatic logic [15:0] scc_strap_mv(input logic [3:0] k);
      case (k)
         4'h0:    scc_strap_mv = `SCC_VSTRAP_MV_0;
         4'h1:    scc_strap_mv = `SCC_VSTRAP_MV_1;
         4'h2:    scc_strap_mv = `SCC_VSTRAP_MV_2;
         4'h3:    scc_strap_mv = `SCC_VSTRAP_MV_3;
         4'h4:    scc_strap_mv = `SCC_VSTRAP_MV_4;
         4'h5:    scc_strap_mv = `SCC_VSTRAP_MV_5;
         4'h6:    scc_strap_mv = `SCC_VSTRAP_MV_6;
         4'h7:    scc_strap_mv = `SCC_VSTRAP_MV_7;
         default: scc_strap_mv = `SCC_VSTRAP_MV_8;
      endcase
   endfunction : scc_strap_mv

   function automatic logic [15:0] scc_clamp_mv(input logic [15:0] v, input logic [15:0] hi);
      if (v < `SCC_VOUT_MIN_MV) scc_clamp_mv = `SCC_VOUT_MIN_MV;
      else if (v > hi)          scc_clamp_mv = hi;
      else                      scc_clamp_mv = v;
   endfunction : scc_clamp_mv

   // pin decode: set-point and address
   always_comb begin
      logic [1:0]  cf;
      logic [1:0]  cc;
      logic [1:0]  al;
      logic [1:0]  ah;
      logic [15:0] steps;
      cf    = pif.cls[`SCC_PIN_VOUT_FINE];
      cc    = pif.cls[`SCC_PIN_VOUT_COARSE];
      al    = pif.cls[`SCC_PIN_ADDR_LO];
      ah    = pif.cls[`SCC_PIN_ADDR_HI];
      steps = 16'(pif.idx[`SCC_PIN_VOUT_COARSE]) * `SCC_STEPS_PER_COARSE + 16'(pif.idx[`SCC_PIN_VOUT_FINE]);
      if (cf != 2'(scc_pkg::SCC_PIN_RES) && cc != 2'(scc_pkg::SCC_PIN_RES))
         pin_mv = scc_strap_mv(4'(cc) * 4'(`SCC_STRAP_STATES) + 4'(cf));
      else if (cf == 2'(scc_pkg::SCC_PIN_RES) && cc == 2'(scc_pkg::SCC_PIN_RES))
         pin_mv = scc_clamp_mv(16'(steps * `SCC_VSTEP_MV), `SCC_OUTPUT_VOLTAGE_CEILING_MV);
      else
         pin_mv = `SCC_VOUT_MIN_MV; // mixed strap and resistor: lowest safe set-point
      if (al == 2'(scc_pkg::SCC_PIN_RES))
         pin_addr = `SCC_ADDR_RES_BASE + 7'(pif.idx[`SCC_PIN_ADDR_LO]);
      else
         pin_addr = `SCC_ADDR_BASE + 7'(ah) * 7'(`SCC_STRAP_STATES) + 7'(al);
   end

   assign ceil_full = 20'(pin_mv) * `SCC_CEIL_NUM / `SCC_CEIL_DEN;
   // host writes stay under the pin ceiling and never leave the regulator's 3.6 V range
   assign host_hi   = (st_q.vceil > `SCC_OUTPUT_VOLTAGE_CEILING_MV) ? `SCC_OUTPUT_VOLTAGE_CEILING_MV : st_q.vceil;
   assign host_mv   = scc_clamp_mv(wr_data[15:0], host_hi);

   // write address and data may arrive in either order; the response waits for both
   assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
   assign s_axi_wready  = !st_q.w_got && !st_q.bvalid;
   assign s_axi_arready = !st_q.rvalid;
   assign wr_addr = st_q.aw_got ? st_q.awaddr : s_axi_awaddr;
   assign wr_data = st_q.w_got ? st_q.wdata : s_axi_wdata;
   assign wr_strb = st_q.w_got ? st_q.wstrb : s_axi_wstrb;
   assign wr_fire = (st_q.aw_got || (s_axi_awvalid && s_axi_awready)) &&
                    (st_q.w_got || (s_axi_wvalid && s_axi_wready));
   assign rd_fire = s_axi_arvalid && s_axi_arready;

   always_comb begin
      logic [11:0] ra;
      logic [11:0] wa;
      st_d = st_q;
      ra   = {s_axi_araddr[11:2], 2'b00};
      wa   = {wr_addr[11:2], 2'b00};
      st_d.req = 1'b0;
      case (st_q.fsm)
         scc_pkg::SCC_ST_IDLE: begin
            st_d.fsm = scc_pkg::SCC_ST_IDLE;
         end
         scc_pkg::SCC_ST_SAMPLE: begin
            st_d.ready = 1'b0;
            if (pif.sample_done)
               st_d.fsm = scc_pkg::SCC_ST_DECODE;
         end
         scc_pkg::SCC_ST_DECODE: begin
            st_d.vset  = pin_mv;
            st_d.vceil = ceil_full[15:0];
            st_d.addr  = pin_addr;
            st_d.ready = 1'b1;
            st_d.fsm   = scc_pkg::SCC_ST_READY;
         end
         default: begin
            st_d.fsm = scc_pkg::SCC_ST_READY;
         end
      endcase
      if (st_q.nvm_busy) begin
         if (st_q.nvm_cnt == 16'h0001) st_d.nvm_busy = 1'b0;
         st_d.nvm_cnt = st_q.nvm_cnt - 16'h0001;
      end
      // write channel
      if (s_axi_awvalid && s_axi_awready) begin
         st_d.aw_got = 1'b1;
         st_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_d.w_got = 1'b1;
         st_d.wdata = s_axi_wdata;
         st_d.wstrb = s_axi_wstrb;
      end
      if (wr_fire) begin
         st_d.aw_got = 1'b0;
         st_d.w_got  = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp  = `SCC_RESP_OKAY;
         if (wa == `SCC_OFS_CTRL) begin
            if (wr_strb[0] && wr_data[`SCC_CTRL_RESTORE] && st_q.fsm != scc_pkg::SCC_ST_SAMPLE) begin
               st_d.fsm   = scc_pkg::SCC_ST_SAMPLE;
               st_d.req   = 1'b1;
               st_d.ready = 1'b0;
            end
            if (wr_strb[0] && wr_data[`SCC_CTRL_STORE] && !st_q.nvm_busy) begin
               st_d.nvm_vout = st_q.vset;
               st_d.nvm_busy = 1'b1;
               st_d.nvm_cnt  = 16'(NVM_CYC);
            end
         end else if (wa == `SCC_OFS_VSET) begin
            if (wr_strb[1:0] == 2'b11 && st_q.fsm == scc_pkg::SCC_ST_READY)
               st_d.vset = host_mv;
         end else if (wa == `SCC_OFS_STATUS || wa == `SCC_OFS_PINS || wa == `SCC_OFS_ADDR ||
                      wa == `SCC_OFS_VCEIL || wa == `SCC_OFS_NVM) begin
            st_d.bresp = `SCC_RESP_OKAY; // read-only: ignored
         end else begin
            st_d.bresp = `SCC_RESP_SLVERR;
         end
      end
      if (st_q.bvalid && s_axi_bready)
         st_d.bvalid = 1'b0;
      // read channel
      if (st_q.rvalid && s_axi_rready)
         st_d.rvalid = 1'b0;
      if (rd_fire) begin
         st_d.rvalid = 1'b1;
         st_d.rresp  = `SCC_RESP_OKAY;
         st_d.rdata  = 32'h00000000;
         if (ra == `SCC_OFS_CTRL)
            st_d.rdata = 32'h00000000;
         else if (ra == `SCC_OFS_STATUS)
            st_d.rdata = {29'h0, st_q.fsm == scc_pkg::SCC_ST_SAMPLE, st_q.nvm_busy, st_q.ready};
         else if (ra == `SCC_OFS_PINS)
            st_d.rdata = {4'h0, pif.idx, pif.cls[3], pif.cls[2], pif.cls[1], pif.cls[0]};
         else if (ra == `SCC_OFS_ADDR)
            st_d.rdata = {25'h0, st_q.addr};
         else if (ra == `SCC_OFS_VSET)
            st_d.rdata = {16'h0, st_q.vset};
         else if (ra == `SCC_OFS_VCEIL)
            st_d.rdata = {16'h0, st_q.vceil};
         else if (ra == `SCC_OFS_NVM)
            st_d.rdata = {16'h0, st_q.nvm_vout};
         else
            st_d.rresp = `SCC_RESP_SLVERR;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) st_q <= RESET_ST;
      else        st_q <= st_d;
   end

   assign pif.sample_req         = st_q.req;
   assign config_ready           = st_q.ready;
   assign serial_addr            = st_q.addr;
   assign vout_setpoint_mv       = st_q.vset;
   assign output_voltage_ceiling = st_q.vceil;
   assign nvm_busy               = st_q.nvm_busy;
   assign s_axi_bvalid           = st_q.bvalid;
   assign s_axi_bresp            = st_q.bresp;
   assign s_axi_rvalid           = st_q.rvalid;
   assign s_axi_rdata            = st_q.rdata;
   assign s_axi_rresp            = st_q.rresp;

   chk_ready_after_decode: assert property (@(posedge clock) disable iff (!rst_n)
      st_q.fsm == scc_pkg::SCC_ST_DECODE |=> config_ready && st_q.fsm == scc_pkg::SCC_ST_READY)
      else $error("decode did not raise config_ready");
   chk_no_ready_sample: assert property (@(posedge clock) disable iff (!rst_n)
      st_q.fsm == scc_pkg::SCC_ST_SAMPLE |=> !config_ready || st_q.fsm == scc_pkg::SCC_ST_DECODE)
      else $error("config_ready high while sampling");
   chk_ceiling_ten_pct: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(config_ready) |-> 20'(output_voltage_ceiling) == 20'(vout_setpoint_mv) * 20'h0000B / 20'h0000A)
      else $error("ceiling not ten percent above set-point");
   chk_restore_sample: assert property (@(posedge clock) disable iff (!rst_n)
      wr_fire && {wr_addr[11:2], 2'b00} == `SCC_OFS_CTRL && wr_strb[0] && wr_data[`SCC_CTRL_RESTORE] &&
      st_q.fsm == scc_pkg::SCC_ST_READY |=> !config_ready ##1 pif.sample_req == 1'b0)
      else $error("restore did not start a new sample");
   chk_vset_range: assert property (@(posedge clock) disable iff (!rst_n)
      config_ready |-> vout_setpoint_mv >= 16'h0258 && vout_setpoint_mv <= 16'h0E10)
      else $error("set-point outside 0.6 V to 3.6 V");
   chk_strap_address: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(config_ready) && pif.cls[0] != scc_pkg::SCC_PIN_RES |->
      serial_addr == 7'h20 + 7'(pif.cls[1]) * 7'h03 + 7'(pif.cls[0]))
      else $error("serial address does not follow address pins");
   chk_nvm_copy: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(nvm_busy) |-> st_q.nvm_vout == $past(st_q.vset) ##1 nvm_busy)
      else $error("store did not copy the set-point");
   chk_host_write: assert property (@(posedge clock) disable iff (!rst_n)
      wr_fire && {wr_addr[11:2], 2'b00} == `SCC_OFS_VSET && wr_strb[1:0] == 2'b11 &&
      st_q.fsm == scc_pkg::SCC_ST_READY |=> vout_setpoint_mv == $past(host_mv) && s_axi_bvalid)
      else $error("host set-point write not applied");
   chk_hold_settings: assert property (@(posedge clock) disable iff (!rst_n)
      st_q.fsm == scc_pkg::SCC_ST_READY && !wr_fire |=> $stable(serial_addr) && $stable(vout_setpoint_mv))
      else $error("settings changed without a sample or host write");
endmodule : scc_strap_capture

// ==== sim/scc_strap_model.sv ====
// board strap model: turns a chosen pin connection into the raw sense lines
`timescale 1ns/1ps
module scc_strap_model (
   input  wire logic [3:0][1:0] cls,
   input  wire logic [3:0][4:0] idx,
   output logic      [31:0]     pin_sense
);
   // a pin without a resistor still shows a junk index, so the decoder must gate on the detect bit
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         pin_sense[8*p +: 8] = {(cls[p] == 2'h3) ? idx[p] : ~idx[p], cls[p] == 2'h3, cls[p] == 2'h0, cls[p] == 2'h2};
      end
   end
endmodule : scc_strap_model

// ==== sim/test_strap_config_capture.sv ====
// self-checking bench for the strap configuration capture block
`timescale 1ns/1ps
`include "scc_consts.svh"
module test_strap_config_capture;
   localparam int VTBL [9] = '{`SCC_VSTRAP_MV_0, `SCC_VSTRAP_MV_1, `SCC_VSTRAP_MV_2, `SCC_VSTRAP_MV_3,
      `SCC_VSTRAP_MV_4, `SCC_VSTRAP_MV_5, `SCC_VSTRAP_MV_6, `SCC_VSTRAP_MV_7, `SCC_VSTRAP_MV_8};
   logic            clock = 1'b0;
   logic            rst_n = 1'b0;
   logic [3:0][1:0] cls   = '0;
   logic [3:0][4:0] idx   = '0;
   logic [31:0]     pin_sense;
   logic            config_ready, nvm_busy;
   logic [6:0]      serial_addr;
   logic [15:0]     vout_setpoint_mv, output_voltage_ceiling;
   logic [11:0]     s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0]     s_axi_wdata = '0, s_axi_rdata;
   logic [3:0]      s_axi_wstrb = '0;
   logic            s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic            s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]      s_axi_bresp, s_axi_rresp;
   int              n_errors = 0;
   int              comparisons = 0;

   always #10 clock = ~clock;

   scc_strap_model u_scc_strap_model (.cls(cls), .idx(idx), .pin_sense(pin_sense));

   scc_strap_capture #(.SETTLE_CYC(2), .NVM_CYC(8)) u_scc_strap_capture (
      .clock(clock), .rst_n(rst_n), .pin_sense(pin_sense), .config_ready(config_ready),
      .serial_addr(serial_addr), .vout_setpoint_mv(vout_setpoint_mv),
      .output_voltage_ceiling(output_voltage_ceiling), .nvm_busy(nvm_busy),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   task automatic complete_run();
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : complete_run

   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : check

   function automatic logic [15:0] exp_mv(input logic [3:0][1:0] c, input logic [3:0][4:0] x);
      int v;
      v = `SCC_VOUT_MIN_MV;
      if (c[2] < 3 && c[3] < 3) v = VTBL[c[3] * 3 + c[2]];
      else if (c[2] == 3 && c[3] == 3) v = 10 * (25 * x[3] + x[2]);
      if (v < `SCC_VOUT_MIN_MV) v = `SCC_VOUT_MIN_MV;
      if (v > `SCC_OUTPUT_VOLTAGE_CEILING_MV) v = `SCC_OUTPUT_VOLTAGE_CEILING_MV;
      return 16'(v);
   endfunction : exp_mv

   function automatic logic [6:0] exp_addr(input logic [3:0][1:0] c, input logic [3:0][4:0] x);
      if (c[0] == 3) return `SCC_ADDR_RES_BASE + 7'(x[0]);
      return `SCC_ADDR_BASE + 7'(c[1] * 3 + c[0]);
   endfunction : exp_addr

   // stimulus changes only just after a rising edge; handshakes are judged at the falling edge before it
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      logic aw, w, b;
      int   t;
      aw = 1'b1; w = 1'b1; b = 1'b0; t = 0; r = 2'h3;
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      while (!b && t < 100) begin
         @(negedge clock);
         t++;
         if (s_axi_bvalid === 1'b1 && !aw && !w) begin b = 1'b1; r = s_axi_bresp; end
         if (s_axi_awready === 1'b1) aw = 1'b0;
         if (s_axi_wready === 1'b1) w = 1'b0;
         @(posedge clock);
         if (!aw) s_axi_awvalid <= 1'b0;
         if (!w) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      @(posedge clock);
      check("write answer", 1'b1, b);
   endtask : axi_wr

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar, got;
      int   t;
      ar = 1'b1; got = 1'b0; t = 0; d = '0; r = 2'h3;
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      while (!got && t < 100) begin
         @(negedge clock);
         t++;
         if (s_axi_rvalid === 1'b1 && !ar) begin got = 1'b1; d = s_axi_rdata; r = s_axi_rresp; end
         if (s_axi_arready === 1'b1) ar = 1'b0;
         @(posedge clock);
         if (!ar) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      @(posedge clock);
      check("read answer", 1'b1, got);
   endtask : axi_rd

   task automatic wait_ready();
      int t;
      t = 0;
      do begin
         @(negedge clock);
         t++;
      end while (config_ready !== 1'b1 && t < 200);
      @(posedge clock);
   endtask : wait_ready

   task automatic resample(input logic [3:0][1:0] c, input logic [3:0][4:0] x);
      logic [31:0] d;
      logic [1:0]  r;
      logic [15:0] mv;
      cls <= c;
      idx <= x;
      mv = exp_mv(c, x);
      axi_wr(`SCC_OFS_CTRL, 32'h0000_0001, 4'hF, r);
      check("ready during sampling", 1'b0, config_ready);
      wait_ready();
      check("config_ready", 1'b1, config_ready);
      check("serial_addr", exp_addr(c, x), serial_addr);
      check("setpoint", mv, vout_setpoint_mv);
      check("ceiling", 16'(32'(mv) * 11 / 10), output_voltage_ceiling);
      axi_rd(`SCC_OFS_PINS, d, r);
      check("pin classes", c, d[7:0]);
      for (int p = 0; p < 4; p++) begin
         if (c[p] == 2'h3) check("pin index", x[p], d[8+5*p +: 5]);
      end
      axi_rd(`SCC_OFS_VSET, d, r);
      check("vset readback", mv, d);
   endtask : resample

   initial begin
      #400000;
      n_errors++;
      $display("ERROR watchdog expected %h seen %h", 1'b0, 1'b1);
      complete_run();
   end

   initial begin
      logic [3:0][1:0] c;
      logic [3:0][4:0] x;
      logic [31:0]     d;
      logic [1:0]      r;
      logic            seen [128];
      logic [31:0]     wv [4] = '{32'h0000_0FA0, 32'h0000_01F4, 32'h0000_04D2, 32'h0000_07D0};
      logic [3:0]      ws [4] = '{4'hF, 4'hF, 4'hF, 4'h1};
      logic [15:0]     we [4] = '{16'h0E10, 16'h0258, 16'h04D2, 16'h04D2};
      seen = '{default: 1'b0};
      void'($urandom(32'hACB02421));
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      @(negedge clock);
      check("ready at release", 1'b0, config_ready);
      wait_ready();
      check("power-up addr", `SCC_ADDR_BASE, serial_addr);
      check("power-up setpoint", `SCC_VOUT_MIN_MV, vout_setpoint_mv);
      // all nine strap pairs on both pin pairs at once
      for (int i = 0; i < 9; i++) begin
         c = '0;
         c[0] = 2'(i % 3); c[1] = 2'(i / 3); c[2] = 2'(i % 3); c[3] = 2'(i / 3);
         x = 20'($urandom());
         resample(c, x);
         check("addr unique", 1'b0, seen[serial_addr]);
         seen[serial_addr] = 1'b1;
      end
      resample(8'hFF, '0);
      resample(8'hFF, {4{5'h1E}});
      for (int i = 0; i < 16; i++) begin
         for (int p = 0; p < 4; p++) begin
            c[p] = 2'($urandom_range(3, 0));
            x[p] = 5'($urandom_range(30, 0));
         end
         if (i % 2 == 0) begin c[2] = 2'h3; c[3] = 2'h3; end
         resample(c, x);
      end
      // host overrides: clamp to ceiling and floor, partial strobe ignored
      resample(8'hA0, '0);
      for (int i = 0; i < 4; i++) begin
         axi_wr(`SCC_OFS_VSET, wv[i], ws[i], r);
         axi_rd(`SCC_OFS_VSET, d, r);
         check("vset host write", we[i], d);
         check("setpoint out", we[i], vout_setpoint_mv);
      end
      axi_wr(`SCC_OFS_ADDR, 32'h0000_007F, 4'hF, r);
      check("addr write resp", `SCC_RESP_OKAY, r);
      axi_wr(`SCC_OFS_VCEIL, 32'h0000_0FFF, 4'hF, r);
      check("addr held", `SCC_ADDR_BASE, serial_addr);
      check("ceiling held", 16'h0F78, output_voltage_ceiling);
      axi_wr(`SCC_OFS_CTRL, 32'h0000_0002, 4'hF, r);
      check("nvm busy", 1'b1, nvm_busy);
      for (int t = 0; t < 100 && nvm_busy === 1'b1; t++) @(posedge clock);
      check("nvm done", 1'b0, nvm_busy);
      axi_rd(`SCC_OFS_NVM, d, r);
      check("nvm copy", 32'h0000_04D2, d);
      axi_rd(12'h020, d, r);
      check("unmapped resp", `SCC_RESP_SLVERR, r);
      check("unmapped data", 32'h0, d);
      axi_rd(`SCC_OFS_STATUS, d, r);
      check("status ready", 1'b1, d[0]);
      resample(8'hA0, '0);
      complete_run();
   end
endmodule : test_strap_config_capture
